// File: verilog/ppfm_top.sv
// Notes on behaviour
// - a shared pin goes to its highest-priority enabled function
// - port t: routed pwm beats timer channels, which beat gpio
// - port s bit 1 carries serial transmit when enabled, else gpio
// - port s bit 0 carries serial receive when enabled; bits 2, 3 gpio only
// - port m bits 5..0: sck, mosi, ss, miso, can transmit, can receive
// - port p low four bits: pwm beats gpio; all eight bits interrupt inputs
// - port j bits 1 and 0: gpio or external interrupt sources
// - each port p and j pin has its own enable and flag
// - every pin has direction, reduced drive, pull enable and polarity
// - each output has two drive strengths chosen by a reduce bit
// - each input selects pull-up or pull-down
// - ports with the option support open-drain output
// - interrupt inputs are glitch filtered before flags set
// - pwm routed to port t stays on port p as well
`timescale 1ns/1ps
`default_nettype none
module ppfm_top
    import ppfm_pkg::*;
#(
    parameter int FILT_CYC = GLITCH_CYC
) (
    input  wire logic                mclk_i,
    input  wire logic                rstn_i,
    // pads
    input  wire logic [T_W-1:0]      port_t_pins_i,
    output var  logic [T_W-1:0]      port_t_pins_o,
    output var  logic [T_W-1:0]      port_t_pins_oen_o,
    input  wire logic [S_W-1:0]      port_s_pins_i,
    output var  logic [S_W-1:0]      port_s_pins_o,
    output var  logic [S_W-1:0]      port_s_pins_oen_o,
    input  wire logic [M_W-1:0]      port_m_pins_i,
    output var  logic [M_W-1:0]      port_m_pins_o,
    output var  logic [M_W-1:0]      port_m_pins_oen_o,
    input  wire logic [P_W-1:0]      port_p_pins_i,
    output var  logic [P_W-1:0]      port_p_pins_o,
    output var  logic [P_W-1:0]      port_p_pins_oen_o,
    input  wire logic [J_W-1:0]      port_j_pins_i,
    output var  logic [J_W-1:0]      port_j_pins_o,
    output var  logic [J_W-1:0]      port_j_pins_oen_o,
    output var  logic [NUM_PINS-1:0] pad_drive_low_o,
    output var  logic [NUM_PINS-1:0] pad_pull_en_o,
    output var  logic [NUM_PINS-1:0] pad_pull_dn_o,
    output var  logic [NUM_PINS-1:0] pad_in_o,
    // per-pin configuration
    input  wire logic [NUM_PINS-1:0] gpio_data_i,
    input  wire logic [NUM_PINS-1:0] gpio_dir_i,
    input  wire logic [NUM_PINS-1:0] drive_reduce_i,
    input  wire logic [NUM_PINS-1:0] pull_en_i,
    input  wire logic [NUM_PINS-1:0] pull_sel_i,
    input  wire logic [OD_W-1:0]     open_drain_i,
    input  wire logic [PWM_CH-1:0]   pwm_route_select_i,
    // peripherals
    input  wire logic [PWM_CH-1:0]   pwm_out_i,
    input  wire logic [PWM_CH-1:0]   pwm_en_i,
    input  wire logic [TIM_CH-1:0]   timer_capture_channel_i,
    input  wire logic [TIM_CH-1:0]   timer_capture_channel_en_i,
    output var  logic [TIM_CH-1:0]   timer_capture_channel_o,
    input  wire logic                sci_tx_i,
    input  wire logic                sci_tx_en_i,
    input  wire logic                sci_rx_en_i,
    output var  logic                sci_rx_o,
    input  wire logic                spi_en_i,
    input  wire logic [SPI_W-1:0]    spi_out_i,
    input  wire logic [SPI_W-1:0]    spi_oe_i,
    output var  logic [SPI_W-1:0]    spi_in_o,
    input  wire logic                can_en_i,
    input  wire logic                can_tx_pin_i,
    output var  logic                can_rx_pin_o,
    // interrupt pins: port p in high bits, port j in low bits
    input  wire logic [IRQ_W-1:0]    irq_en_i,
    input  wire logic [IRQ_W-1:0]    irq_clr_i,
    output var  logic [IRQ_W-1:0]    irq_flag_o,
    output var  logic                port_p_irq_o,
    output var  logic                port_j_irq_o,
    output var  logic                rom_enable_strap_o
);
    if (FILT_CYC < 1) begin : g_bad
        $error("FILT_CYC must be at least one");
    end

    // ****************************************************
    // helpers
    // ****************************************************
    // open-drain drives only the low level, a high is released
    function automatic logic pad_release(input logic drv, input logic val, input logic od);
        pad_release = !drv || (od && val);
    endfunction : pad_release

    function automatic logic irq_edge(input logic now, input logic prev, input logic rise);
        irq_edge = rise ? (now && !prev) : (!now && prev);
    endfunction : irq_edge

    // ****************************************************
    // pin input synchroniser
    // ****************************************************
    logic [NUM_PINS-1:0] pin_in_w;
    logic [NUM_PINS-1:0] meta_r;
    assign pin_in_w = {port_t_pins_i, port_s_pins_i, port_m_pins_i, port_p_pins_i, port_j_pins_i};

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            meta_r   <= '0;
            pad_in_o <= '0;
        end else begin
            meta_r   <= pin_in_w;
            pad_in_o <= meta_r;
        end
    end

    // ****************************************************
    // function select, lowest priority written first
    // ****************************************************
    logic [NUM_PINS-1:0] out_c;
    logic [NUM_PINS-1:0] drv_c;
    logic [NUM_PINS-1:0] od_c;
    logic [NUM_PINS-1:0] oen_c;

    always_comb begin
        out_c = gpio_data_i;
        drv_c = gpio_dir_i;
        od_c  = '0;
        od_c[OFS_S +: S_W] = open_drain_i[0 +: S_W];
        od_c[OFS_M +: M_W] = open_drain_i[S_W +: M_W];
        for (int k = 0; k < TIM_CH; k++) begin
            if (timer_capture_channel_en_i[k]) begin
                out_c[OFS_T + TIM_LSB + k] = timer_capture_channel_i[k];
                drv_c[OFS_T + TIM_LSB + k] = 1'h1;
            end
        end
        for (int k = 0; k < PWM_CH; k++) begin
            if (pwm_route_select_i[k] && pwm_en_i[k]) begin
                out_c[OFS_T + k] = pwm_out_i[k];
                drv_c[OFS_T + k] = 1'h1;
            end
            // routing to port t never takes the channel off port p
            if (pwm_en_i[k]) begin
                out_c[OFS_P + k] = pwm_out_i[k];
                drv_c[OFS_P + k] = 1'h1;
            end
        end
        if (sci_tx_en_i) begin
            out_c[OFS_S + S_TX] = sci_tx_i;
            drv_c[OFS_S + S_TX] = 1'h1;
        end
        if (sci_rx_en_i) begin
            drv_c[OFS_S + S_RX] = 1'h0;
        end
        if (spi_en_i) begin
            for (int k = 0; k < SPI_W; k++) begin
                out_c[OFS_M + SPI_LSB + k] = spi_out_i[k];
                drv_c[OFS_M + SPI_LSB + k] = spi_oe_i[k];
            end
        end
        if (can_en_i) begin
            out_c[OFS_M + M_CAN_TX] = can_tx_pin_i;
            drv_c[OFS_M + M_CAN_TX] = 1'h1;
            drv_c[OFS_M + M_CAN_RX] = 1'h0;
        end
        for (int i = 0; i < NUM_PINS; i++) begin
            oen_c[i] = pad_release(drv_c[i], out_c[i], od_c[i]);
        end
    end

    // ****************************************************
    // pad drive registers
    // ****************************************************
    logic [NUM_PINS-1:0] pad_out_r;
    logic [NUM_PINS-1:0] pad_oen_r;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            pad_out_r <= {NUM_PINS{PIN_OUT_RST}};
            pad_oen_r <= {NUM_PINS{PIN_OEN_RST}};
        end else begin
            pad_out_r <= out_c;
            pad_oen_r <= oen_c;
        end
    end

    assign port_t_pins_o     = pad_out_r[OFS_T +: T_W];
    assign port_t_pins_oen_o = pad_oen_r[OFS_T +: T_W];
    assign port_s_pins_o     = pad_out_r[OFS_S +: S_W];
    assign port_s_pins_oen_o = pad_oen_r[OFS_S +: S_W];
    assign port_m_pins_o     = pad_out_r[OFS_M +: M_W];
    assign port_m_pins_oen_o = pad_oen_r[OFS_M +: M_W];
    assign port_p_pins_o     = pad_out_r[OFS_P +: P_W];
    assign port_p_pins_oen_o = pad_oen_r[OFS_P +: P_W];
    assign port_j_pins_o     = pad_out_r[OFS_J +: J_W];
    assign port_j_pins_oen_o = pad_oen_r[OFS_J +: J_W];

    // ****************************************************
    // drive strength and pull devices
    // ****************************************************
    // pulls are cut while the pin drives, saving current against itself
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            pad_drive_low_o <= '0;
            pad_pull_en_o   <= '0;
            pad_pull_dn_o   <= '0;
        end else begin
            pad_drive_low_o <= drive_reduce_i;
            pad_pull_en_o   <= pull_en_i & ~drv_c;
            pad_pull_dn_o   <= pull_sel_i;
        end
    end

    // ****************************************************
    // inputs back to peripherals
    // ****************************************************
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            timer_capture_channel_o <= '0;
            sci_rx_o                <= RX_IDLE;
            spi_in_o                <= '0;
            can_rx_pin_o            <= RX_IDLE;
        end else begin
            timer_capture_channel_o <= pad_in_o[OFS_T + TIM_LSB +: TIM_CH];
            sci_rx_o     <= sci_rx_en_i ? pad_in_o[OFS_S + S_RX] : RX_IDLE;
            spi_in_o     <= spi_en_i ? pad_in_o[OFS_M + SPI_LSB +: SPI_W] : '0;
            can_rx_pin_o <= can_en_i ? pad_in_o[OFS_M + M_CAN_RX] : RX_IDLE;
        end
    end

    // ****************************************************
    // rom enable strap
    // ****************************************************
    // wait until the synchroniser holds a real pin sample, then freeze
    logic [1:0] strap_cnt_r;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            strap_cnt_r        <= '0;
            rom_enable_strap_o <= '0;
        end else if (strap_cnt_r != STRAP_WAIT) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r + 2'h1 == STRAP_WAIT) begin
                rom_enable_strap_o <= pad_in_o[OFS_P + P_STRAP];
            end
        end
    end

    // ****************************************************
    // interrupt pins: filter, edge, flag
    // ****************************************************
    logic [IRQ_W-1:0] irq_raw_w;
    logic [IRQ_W-1:0] irq_rise_w;
    logic [IRQ_W-1:0] filt_w;
    logic [IRQ_W-1:0] filt_prev_r;
    logic [IRQ_W-1:0] edge_c;
    logic [IRQ_W-1:0] flag_nxt;

    assign irq_raw_w  = {pad_in_o[OFS_P +: P_W], pad_in_o[OFS_J +: J_W]};
    assign irq_rise_w = {pull_sel_i[OFS_P +: P_W], pull_sel_i[OFS_J +: J_W]};

    ppfm_glitch_filter #(
        .W   (IRQ_W),
        .CYC (FILT_CYC)
    ) u_filt (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .din_i  (irq_raw_w),
        .dout_o (filt_w)
    );

    // a new edge in the clearing cycle keeps the flag set
    always_comb begin
        for (int i = 0; i < IRQ_W; i++) begin
            edge_c[i] = irq_edge(filt_w[i], filt_prev_r[i], irq_rise_w[i]);
        end
        flag_nxt = (irq_flag_o & ~irq_clr_i) | edge_c;
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            filt_prev_r  <= {IRQ_W{FILT_RST_LVL}};
            irq_flag_o   <= '0;
            port_p_irq_o <= 1'h0;
            port_j_irq_o <= 1'h0;
        end else begin
            filt_prev_r  <= filt_w;
            irq_flag_o   <= flag_nxt;
            port_p_irq_o <= |(flag_nxt[J_W +: P_W] & irq_en_i[J_W +: P_W]);
            port_j_irq_o <= |(flag_nxt[0 +: J_W] & irq_en_i[0 +: J_W]);
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    AST_PT_PWM_WINS: assert property (
        pwm_route_select_i[0] && pwm_en_i[0]
        |=> port_t_pins_o[0] == $past(pwm_out_i[0]) && !port_t_pins_oen_o[0])
        else $error("routed pwm not on port t");
    AST_PT_TIMER: assert property (
        timer_capture_channel_en_i[0] && !(pwm_route_select_i[2] && pwm_en_i[2])
        |=> port_t_pins_o[2] == $past(timer_capture_channel_i[0]))
        else $error("timer channel not on port t");
    AST_PP_PWM_BOTH: assert property (
        pwm_route_select_i[1] && pwm_en_i[1]
        |=> port_p_pins_o[1] == port_t_pins_o[1] && !port_p_pins_oen_o[1])
        else $error("routed pwm left port p");
    AST_PS_TX: assert property (
        sci_tx_en_i && !open_drain_i[S_TX]
        |=> port_s_pins_o[1] == $past(sci_tx_i) && !port_s_pins_oen_o[1])
        else $error("serial transmit not on port s");
    AST_PS_RX: assert property (
        sci_rx_en_i |=> port_s_pins_oen_o[0]
        ##1 sci_rx_o == $past(pad_in_o[OFS_S + S_RX]) || !$past(sci_rx_en_i))
        else $error("serial receive path wrong");
    AST_PM_CAN: assert property (
        can_en_i && !open_drain_i[S_W + M_CAN_TX]
        |=> port_m_pins_o[1] == $past(can_tx_pin_i) && port_m_pins_oen_o[0])
        else $error("can pins wrong");
    AST_GPIO_ONLY: assert property (
        gpio_dir_i[OFS_P + 7] |=> port_p_pins_o[7] == $past(gpio_data_i[OFS_P + 7])
        && !port_p_pins_oen_o[7])
        else $error("gpio not driving idle pin");
    AST_OPEN_DRAIN: assert property (
        open_drain_i[2] && gpio_dir_i[OFS_S + 2] && gpio_data_i[OFS_S + 2]
        |=> port_s_pins_oen_o[2])
        else $error("open drain drove a high");
    AST_PULL: assert property (
        pull_en_i[OFS_P + 7] && !gpio_dir_i[OFS_P + 7]
        |=> pad_pull_en_o[OFS_P + 7] && pad_pull_dn_o[OFS_P + 7] == $past(pull_sel_i[OFS_P + 7]))
        else $error("pull device not applied");
    AST_DRIVE: assert property (
        $changed(drive_reduce_i[0]) |=> pad_drive_low_o[0] == $past(drive_reduce_i[0]))
        else $error("drive strength not applied");
    AST_FLAG_CAUSE: assert property (
        $rose(irq_flag_o[0]) |-> $past(filt_w[0] != filt_prev_r[0]))
        else $error("flag set without filtered edge");
    AST_FLAG_HOLD: assert property (
        irq_flag_o[0] && !irq_clr_i[0] |=> irq_flag_o[0])
        else $error("flag lost without clear");
    AST_STRAP_FROZEN: assert property (
        strap_cnt_r == STRAP_WAIT |=> $stable(rom_enable_strap_o))
        else $error("strap moved after capture");

    COV_ROUTED_PWM: cover property (pwm_route_select_i[0] && pwm_en_i[0] ##1 port_t_pins_o[0]);
    COV_FLAG_SET:   cover property ($rose(irq_flag_o[IRQ_W-1]));
    COV_SET_CLEAR:  cover property (irq_clr_i[0] && edge_c[0]);
    COV_SPI_ON:     cover property (spi_en_i && spi_oe_i[3]);
endmodule : ppfm_top
`default_nettype wire

// File: verilog/ppfm_pkg.sv
`default_nettype none
package ppfm_pkg;
    // ****************************************************
    // pin map: one flat vector, port j lowest, port t highest
    // ****************************************************
    localparam int T_W      = 8;
    localparam int S_W      = 4;
    localparam int M_W      = 6;
    localparam int P_W      = 8;
    localparam int J_W      = 2;
    localparam int OFS_J    = 0;
    localparam int OFS_P    = OFS_J + J_W;
    localparam int OFS_M    = OFS_P + P_W;
    localparam int OFS_S    = OFS_M + M_W;
    localparam int OFS_T    = OFS_S + S_W;
    localparam int NUM_PINS = OFS_T + T_W;
    localparam int OD_W     = S_W + M_W;
    localparam int IRQ_W    = P_W + J_W;

    // ****************************************************
    // peripheral positions
    // ****************************************************
    localparam int PWM_CH   = 4;
    localparam int TIM_CH   = 6;
    localparam int TIM_LSB  = 2;
    localparam int SPI_W    = 4;
    localparam int SPI_LSB  = 2;
    localparam int S_RX     = 0;
    localparam int S_TX     = 1;
    localparam int M_CAN_RX = 0;
    localparam int M_CAN_TX = 1;
    localparam int P_STRAP  = 6;

    // ****************************************************
    // timing
    // ****************************************************
    localparam int CLK_MHZ    = 200;
    localparam int GLITCH_NS  = 20;
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    // first two edges after release still see the synchroniser's reset value
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic PIN_OUT_RST  = 1'h0;
    localparam logic PIN_OEN_RST  = 1'h1;
    localparam logic RX_IDLE      = 1'h1;
    localparam logic FILT_RST_LVL = 1'h0;
endpackage : ppfm_pkg
`default_nettype wire

// File: verilog/ppfm_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ppfm_glitch_filter
    import ppfm_pkg::*;
#(
    parameter int   W   = IRQ_W,
    parameter int   CYC = GLITCH_CYC
) (
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] din_i,
    output var  logic [W-1:0] dout_o
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    if (CYC < 1 || W < 1) begin : g_bad
        $error("glitch filter needs W and CYC of at least one");
    end

    // ****************************************************
    // per-bit stability counter
    // ****************************************************
    // a level is accepted only after CYC equal samples in a row
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic [CW-1:0] cnt_r;
        always_ff @(posedge mclk_i) begin
            if (!rstn_i) begin
                cnt_r     <= '0;
                dout_o[i] <= FILT_RST_LVL;
            end else if (din_i[i] == dout_o[i]) begin
                cnt_r <= '0;
            end else if (cnt_r == LAST) begin
                cnt_r     <= '0;
                dout_o[i] <= din_i[i];
            end else begin
                cnt_r <= cnt_r + CW'(1);
            end
        end
    end
endmodule : ppfm_glitch_filter
`default_nettype wire

// File: dv/ppfm_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// board side: resolves every pad from all its drivers
// ****************************************************
module ppfm_pad_model
    import ppfm_pkg::*;
(
    input  wire logic                mclk_i,
    input  wire logic [NUM_PINS-1:0] pin_i,
    input  wire logic [NUM_PINS-1:0] drive_n_i,
    input  wire logic [NUM_PINS-1:0] pull_en_i,
    input  wire logic [NUM_PINS-1:0] pull_dn_i,
    input  wire logic [NUM_PINS-1:0] ext_val_i,
    input  wire logic [NUM_PINS-1:0] ext_en_i,
    output var  logic [NUM_PINS-1:0] pad_o
);
    logic [NUM_PINS-1:0] last_r;

    // device wins over the board driver; a bare pad never holds its level
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!drive_n_i[i]) begin
                pad_o[i] = pin_i[i];
            end else if (ext_en_i[i]) begin
                pad_o[i] = ext_val_i[i];
            end else if (pull_en_i[i]) begin
                pad_o[i] = ~pull_dn_i[i];
            end else begin
                pad_o[i] = ~last_r[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        last_r <= pad_o;
    end
endmodule : ppfm_pad_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, (a), (b)); end end
module tb_top
    import ppfm_pkg::*;
;
    // ****************************************************
    // stimulus rows and bench signals
    // ****************************************************
    typedef struct packed {
        logic [NUM_PINS-1:0] gd;
        logic [NUM_PINS-1:0] gdir;
        logic [OD_W-1:0]     od;
        logic [PWM_CH-1:0]   pen;
        logic [PWM_CH-1:0]   pout;
        logic [PWM_CH-1:0]   rte;
        logic [TIM_CH-1:0]   ten;
        logic [TIM_CH-1:0]   tv;
        logic [5:0]          misc;
        logic [SPI_W-1:0]    sout;
        logic [SPI_W-1:0]    soe;
        logic [NUM_PINS-1:0] eo;
        logic [NUM_PINS-1:0] eoen;
    } ppfm_row_t;

    logic                mclk_i     = 1'h0;
    logic                rstn_i     = 1'h0;
    ppfm_row_t           cur        = '0;
    ppfm_row_t           rows [8];
    logic [NUM_PINS-1:0] drv_red    = '0;
    logic [NUM_PINS-1:0] pl_en_in   = '0;
    logic [NUM_PINS-1:0] pl_sel     = '0;
    logic [NUM_PINS-1:0] ext_val    = '0;
    logic [NUM_PINS-1:0] ext_en     = '1;
    logic [IRQ_W-1:0]    irq_en     = '0;
    logic [IRQ_W-1:0]    irq_clr    = '0;
    int                  num_errors = 0;
    int                  num_checks = 0;
    wire logic [NUM_PINS-1:0] pin_o, pin_oen, pad, drv_low, pl_en, pl_dn, pad_in;
    wire logic [TIM_CH-1:0]   tim_in;
    wire logic [SPI_W-1:0]    spi_in;
    wire logic [IRQ_W-1:0]    flag;
    wire logic                sci_rx, can_rx, p_irq, j_irq, strap;

    always #2.5 mclk_i = ~mclk_i;

    // short filter keeps the interrupt scenarios brief
    ppfm_top #(.FILT_CYC(2)) u_ppfm_top (
        .mclk_i(mclk_i), .rstn_i(rstn_i),
        .port_t_pins_i(pad[OFS_T+:T_W]), .port_t_pins_o(pin_o[OFS_T+:T_W]),
        .port_t_pins_oen_o(pin_oen[OFS_T+:T_W]),
        .port_s_pins_i(pad[OFS_S+:S_W]), .port_s_pins_o(pin_o[OFS_S+:S_W]),
        .port_s_pins_oen_o(pin_oen[OFS_S+:S_W]),
        .port_m_pins_i(pad[OFS_M+:M_W]), .port_m_pins_o(pin_o[OFS_M+:M_W]),
        .port_m_pins_oen_o(pin_oen[OFS_M+:M_W]),
        .port_p_pins_i(pad[OFS_P+:P_W]), .port_p_pins_o(pin_o[OFS_P+:P_W]),
        .port_p_pins_oen_o(pin_oen[OFS_P+:P_W]),
        .port_j_pins_i(pad[OFS_J+:J_W]), .port_j_pins_o(pin_o[OFS_J+:J_W]),
        .port_j_pins_oen_o(pin_oen[OFS_J+:J_W]),
        .pad_drive_low_o(drv_low), .pad_pull_en_o(pl_en), .pad_pull_dn_o(pl_dn),
        .pad_in_o(pad_in), .gpio_data_i(cur.gd), .gpio_dir_i(cur.gdir),
        .drive_reduce_i(drv_red), .pull_en_i(pl_en_in), .pull_sel_i(pl_sel),
        .open_drain_i(cur.od), .pwm_route_select_i(cur.rte), .pwm_out_i(cur.pout),
        .pwm_en_i(cur.pen), .timer_capture_channel_i(cur.tv),
        .timer_capture_channel_en_i(cur.ten), .timer_capture_channel_o(tim_in),
        .sci_tx_en_i(cur.misc[5]), .sci_tx_i(cur.misc[4]), .sci_rx_en_i(cur.misc[3]),
        .sci_rx_o(sci_rx), .spi_en_i(cur.misc[2]), .spi_out_i(cur.sout),
        .spi_oe_i(cur.soe), .spi_in_o(spi_in), .can_en_i(cur.misc[1]),
        .can_tx_pin_i(cur.misc[0]), .can_rx_pin_o(can_rx), .irq_en_i(irq_en),
        .irq_clr_i(irq_clr), .irq_flag_o(flag), .port_p_irq_o(p_irq),
        .port_j_irq_o(j_irq), .rom_enable_strap_o(strap)
    );

    ppfm_pad_model u_ppfm_pad_model (
        .mclk_i(mclk_i), .pin_i(pin_o), .drive_n_i(pin_oen), .pull_en_i(pl_en),
        .pull_dn_i(pl_dn), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pad)
    );

    // ****************************************************
    // helpers
    // ****************************************************
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick

    // bounded: a missing interrupt ends the run as a failure
    task automatic wait_irq();
        int n;
        n = 0;
        while ((p_irq | j_irq) !== 1'h1 && n < 20) begin
            tick(1);
            n++;
        end
        if ((p_irq | j_irq) !== 1'h1) begin
            num_errors++;
            close_out();
        end
    endtask : wait_irq

    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        // gd, gdir, od, pen, pout, rte, ten, tv, misc, sout, soe, eo, eoen
        rows[0] = {28'hFFFFFFF, 28'hFFFFFFF, 10'h000, 4'h0, 4'h0, 4'h0, 6'h00, 6'h00,
                   6'h00, 4'h0, 4'h0, 28'hFFFFFFF, 28'h0000000};
        rows[1] = {28'hFFFFFFF, 28'h0000000, 10'h000, 4'h0, 4'h0, 4'h0, 6'h00, 6'h00,
                   6'h00, 4'h0, 4'h0, 28'h0000000, 28'hFFFFFFF};
        rows[2] = {28'h0000000, 28'hFFFFFFF, 10'h000, 4'hF, 4'h5, 4'h0, 6'h00, 6'h00,
                   6'h00, 4'h0, 4'h0, 28'h0000014, 28'h0000000};
        rows[3] = {28'h0000000, 28'hFFFFFFF, 10'h000, 4'hF, 4'hA, 4'hF, 6'h3F, 6'h3F,
                   6'h00, 4'h0, 4'h0, 28'hFA00028, 28'h0000000};
        rows[4] = {28'h0000000, 28'h0000000, 10'h000, 4'hF, 4'h0, 4'h3, 6'h3F, 6'h3F,
                   6'h00, 4'h0, 4'h0, 28'hFC00000, 28'h00FFFC3};
        rows[5] = {28'hFFFFFFF, 28'hFFFFFFF, 10'h000, 4'h0, 4'h0, 4'hF, 6'h3F, 6'h00,
                   6'h00, 4'h0, 4'h0, 28'h03FFFFF, 28'h0000000};
        rows[6] = {28'hFFFFFFF, 28'hFFFFFFF, 10'h000, 4'h0, 4'h0, 4'h0, 6'h00, 6'h00,
                   6'h2E, 4'hA, 4'hC, 28'hFFC83FF, 28'h0013400};
        rows[7] = {28'hFF503FF, 28'hFFFFFFF, 10'h3FF, 4'h0, 4'h0, 4'h0, 6'h00, 6'h00,
                   6'h00, 4'h0, 4'h0, 28'hFF003FF, 28'h0050000};
        tick(2);
        rstn_i = 1'h1;
        tick(1);
        `CHK(pin_oen, 28'hFFFFFFF)
        `CHK(pin_o, 28'h0000000)
        `CHK(flag, 10'h000)
        `CHK({sci_rx, can_rx, strap}, 3'h6)
        for (int i = 0; i < 8; i++) begin
            cur = rows[i];
            tick(1);
            `CHK(pin_oen, cur.eoen)
            `CHK(pin_o & ~cur.eoen, cur.eo & ~cur.eoen)
        end
        // pulls and drive strength, pads left to the pull devices
        cur = '0;
        ext_en = '0;
        pl_en_in = '1;
        pl_sel = 28'h5555555;
        drv_red = 28'hA5A5A5A;
        tick(1);
        `CHK(drv_low, 28'hA5A5A5A)
        `CHK(pl_en, 28'hFFFFFFF)
        `CHK(pl_dn, 28'h5555555)
        tick(3);
        `CHK(pad_in, 28'hAAAAAAA)
        // pad levels into the peripherals
        ext_en = '1;
        pl_en_in = '0;
        ext_val = 28'h5A3C96B;
        cur.misc = 6'h0E;
        tick(4);
        `CHK(pad_in, 28'h5A3C16B)
        `CHK(tim_in, 6'h16)
        `CHK({sci_rx, spi_in, can_rx}, 6'h38)
        // interrupts, rising edge selected on every pin
        cur = '0;
        ext_val = '0;
        pl_sel = '1;
        tick(8);
        irq_clr = '1;
        tick(1);
        irq_clr = '0;
        tick(1);
        `CHK(flag, 10'h000)
        for (int k = 0; k < IRQ_W; k++) begin
            irq_en = 10'h001 << k;
            ext_val[k] = 1'h1;
            wait_irq();
            `CHK(flag, 10'h001 << k)
            `CHK({p_irq, j_irq}, (k < J_W) ? 2'h1 : 2'h2)
            ext_val[k] = 1'h0;
            irq_clr = '1;
            tick(1);
            irq_clr = '0;
            tick(8);
            `CHK(flag, 10'h000)
        end
        // one-cycle spike must not reach the flag
        irq_en = '1;
        ext_val[OFS_P] = 1'h1;
        tick(1);
        ext_val[OFS_P] = 1'h0;
        tick(10);
        `CHK(flag, 10'h000)
        // strap is taken once after reset and then frozen
        ext_val[OFS_P+P_STRAP] = 1'h1;
        rstn_i = 1'h0;
        tick(2);
        rstn_i = 1'h1;
        tick(4);
        `CHK(strap, 1'h1)
        ext_val[OFS_P+P_STRAP] = 1'h0;
        tick(4);
        `CHK(strap, 1'h1)
        close_out();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
